// ---- logic/dch_cpu_end.sv ----
`timescale 1ns/1ps
module dch_cpu_end #(
    parameter int DEPTH = 256
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic fast_chassis,
    dch_if.cpu        bus,
    output logic      busy
);
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_GRANT = 3'b001,
        ST_IN    = 3'b010,
        ST_READ  = 3'b011,
        ST_OUT   = 3'b100,
        ST_DONE  = 3'b101
    } cpu_state_t;

    cpu_state_t                  state_q;
    dch_pkg::xfer_mode_t         mode_q;
    logic [dch_pkg::DATA_W-1:0]  mem [DEPTH];
    logic [dch_pkg::DATA_W-1:0]  in_word_q;
    logic [dch_pkg::DATA_W-1:0]  out_word_q;
    logic [dch_pkg::CNT_W-1:0]   cnt_q;
    logic [dch_pkg::CNT_W-1:0]   strobe_len;
    logic [dch_pkg::DATA_W:0]    sum;
    logic [dch_pkg::DATA_W-1:0]  mem_word;
    logic                        wrap_q;
    logic                        strobe_end;

    assign strobe_len = fast_chassis ?
        dch_pkg::CNT_W'(dch_pkg::STROBE_FAST_CYC) :
        dch_pkg::CNT_W'(dch_pkg::STROBE_STD_CYC);
    assign strobe_end = (cnt_q == strobe_len);
    assign mem_word = mem[bus.addr];

    always_comb begin
        if (mode_q == dch_pkg::MODE_INC) begin
            sum = {1'b0, mem_word} + {1'b0, dch_pkg::DATA_ONE};
        end else begin
            sum = {1'b0, mem_word} + {1'b0, in_word_q};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            mode_q  <= dch_pkg::MODE_OUT;
            cnt_q   <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (bus.chan_request) begin
                        mode_q  <= dch_pkg::xfer_mode_t'(
                            {~bus.xfer_mode_sel_a_n,
                             ~bus.xfer_mode_sel_b_n});
                        state_q <= ST_GRANT;
                    end
                end
                ST_GRANT: begin
                    cnt_q <= dch_pkg::CNT_W'(1);
                    if (mode_q == dch_pkg::MODE_IN ||
                        mode_q == dch_pkg::MODE_ADD) begin
                        state_q <= ST_IN;
                    end else begin
                        state_q <= ST_READ;
                    end
                end
                ST_IN: begin
                    if (strobe_end) begin
                        cnt_q   <= '0;
                        state_q <= (mode_q == dch_pkg::MODE_ADD) ?
                                   ST_READ : ST_DONE;
                    end else begin
                        cnt_q <= cnt_q + dch_pkg::CNT_W'(1);
                    end
                end
                ST_READ: begin
                    cnt_q   <= dch_pkg::CNT_W'(1);
                    state_q <= ST_OUT;
                end
                ST_OUT: begin
                    if (strobe_end) begin
                        cnt_q   <= '0;
                        state_q <= ST_DONE;
                    end else begin
                        cnt_q <= cnt_q + dch_pkg::CNT_W'(1);
                    end
                end
                default: begin
                    cnt_q   <= '0;
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_word_q <= dch_pkg::DATA_ZERO;
        end else if (state_q == ST_IN && strobe_end) begin
            in_word_q <= bus.data_to_cpu;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_word_q <= dch_pkg::DATA_ZERO;
            wrap_q     <= 1'b0;
        end else begin
            wrap_q <= 1'b0;
            if (state_q == ST_READ) begin
                if (mode_q == dch_pkg::MODE_OUT) begin
                    out_word_q <= mem_word;
                end else begin
                    out_word_q <= sum[dch_pkg::DATA_W-1:0];
                    wrap_q     <= sum[dch_pkg::DATA_W];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (state_q == ST_IN && strobe_end && mode_q == dch_pkg::MODE_IN) begin
            mem[bus.addr] <= bus.data_to_cpu;
        end else if (state_q == ST_READ && mode_q != dch_pkg::MODE_OUT) begin
            mem[bus.addr] <= sum[dch_pkg::DATA_W-1:0];
        end
    end

    assign bus.data_to_ctl        = out_word_q;
    assign bus.chan_grant         = (state_q == ST_GRANT);
    assign bus.chan_in_strobe     = (state_q == ST_IN);
    assign bus.chan_out_strobe    = (state_q == ST_OUT);
    assign bus.sum_wrap_pulse     = wrap_q;
    assign bus.chan_prio_chain_in = 1'b1;
    assign busy                   = (state_q != ST_IDLE);
endmodule

// ---- logic/dch_ctl_end.sv ----
`timescale 1ns/1ps
module dch_ctl_end (
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    dch_if.ctl                               bus,
    input  wire logic                        req,
    input  wire dch_pkg::xfer_mode_t         req_mode,
    input  wire logic [dch_pkg::ADDR_W-1:0]  req_addr,
    input  wire logic [dch_pkg::DATA_W-1:0]  req_data,
    output logic                             req_ready,
    output logic [dch_pkg::DATA_W-1:0]       rx_data,
    output logic                             rx_valid,
    output logic                             wrap_seen
);
    logic                        active_q;
    dch_pkg::xfer_mode_t         mode_q;
    logic [dch_pkg::ADDR_W-1:0]  addr_q;
    logic [dch_pkg::DATA_W-1:0]  data_q;
    logic                        out_q;
    logic                        last_strobe;
    logic                        last_strobe_q;
    logic                        strobe_done;

    assign out_q = bus.chan_out_strobe;
    assign last_strobe = (mode_q == dch_pkg::MODE_IN) ?
        bus.chan_in_strobe : out_q;
    // Release only once the final strobe has fully ended
    assign strobe_done = last_strobe_q && !last_strobe;
    assign req_ready = !active_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_q <= 1'b0;
            mode_q   <= dch_pkg::MODE_OUT;
            addr_q   <= '0;
            data_q   <= dch_pkg::DATA_ZERO;
        end else if (!active_q) begin
            if (req) begin
                active_q <= 1'b1;
                mode_q   <= req_mode;
                addr_q   <= req_addr;
                data_q   <= req_data;
            end
        end else if (strobe_done) begin
            active_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_strobe_q <= 1'b0;
        end else begin
            last_strobe_q <= last_strobe;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_data   <= dch_pkg::DATA_ZERO;
            rx_valid  <= 1'b0;
            wrap_seen <= 1'b0;
        end else begin
            rx_valid  <= 1'b0;
            wrap_seen <= bus.sum_wrap_pulse;
            if (out_q) begin
                rx_data  <= bus.data_to_ctl;
                rx_valid <= 1'b1;
            end
        end
    end

    assign bus.chan_request        = active_q && bus.chan_prio_chain_in;
    assign bus.chan_prio_chain_out = bus.chan_prio_chain_in &&
                                     !active_q;
    assign bus.xfer_mode_sel_a_n   = ~mode_q[1];
    assign bus.xfer_mode_sel_b_n   = ~mode_q[0];
    assign bus.addr                = addr_q;
    assign bus.data_to_cpu         = data_q;
endmodule

// ---- logic/dch_if.sv ----
`timescale 1ns/1ps
interface dch_if;
    logic [dch_pkg::DATA_W-1:0] data_to_ctl;
    logic [dch_pkg::DATA_W-1:0] data_to_cpu;
    logic [dch_pkg::ADDR_W-1:0] addr;
    logic                       chan_request;
    logic                       chan_grant;
    logic                       xfer_mode_sel_a_n;
    logic                       xfer_mode_sel_b_n;
    logic                       chan_in_strobe;
    logic                       chan_out_strobe;
    logic                       sum_wrap_pulse;
    logic                       chan_prio_chain_in;
    logic                       chan_prio_chain_out;
    modport cpu (
        input  data_to_cpu, addr, chan_request, xfer_mode_sel_a_n,
               xfer_mode_sel_b_n,
        output data_to_ctl, chan_grant, chan_in_strobe, chan_out_strobe,
               sum_wrap_pulse, chan_prio_chain_in
    );
    modport ctl (
        output data_to_cpu, addr, chan_request, xfer_mode_sel_a_n,
               xfer_mode_sel_b_n, chan_prio_chain_out,
        input  data_to_ctl, chan_grant, chan_in_strobe, chan_out_strobe,
               sum_wrap_pulse, chan_prio_chain_in
    );
endinterface

// ---- logic/dch_pkg.sv ----
package dch_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    typedef enum logic [1:0] {
        MODE_OUT  = 2'b00,
        MODE_INC  = 2'b01,
        MODE_IN   = 2'b10,
        MODE_ADD  = 2'b11
    } xfer_mode_t;
    localparam int STROBE_FAST_CYC = 1;
    localparam int STROBE_STD_CYC  = 3;
    localparam int CNT_W           = 4;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_ONE  = 16'h0001;
endpackage

// ---- sim/dch_properties.sv ----
`timescale 1ns/1ps
module dch_properties (
    input wire logic                       clk,
    input wire logic                       rst_n,
    input wire logic [dch_pkg::DATA_W-1:0] data_to_ctl,
    input wire logic [dch_pkg::DATA_W-1:0] data_to_cpu,
    input wire logic                       chan_request,
    input wire logic                       chan_grant,
    input wire logic                       xfer_mode_sel_a_n,
    input wire logic                       xfer_mode_sel_b_n,
    input wire logic                       chan_in_strobe,
    input wire logic                       chan_out_strobe,
    input wire logic                       sum_wrap_pulse,
    input wire logic                       chan_prio_chain_in,
    input wire logic                       chan_prio_chain_out
);
    logic inc_m;
    logic add_m;
    logic in_m;
    assign inc_m = xfer_mode_sel_a_n & ~xfer_mode_sel_b_n;
    assign add_m = ~xfer_mode_sel_a_n & ~xfer_mode_sel_b_n;
    assign in_m  = ~xfer_mode_sel_a_n & xfer_mode_sel_b_n;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    grant_after_req_a: assert property (
        $rose(chan_request) |=> chan_grant)
        else $error("grant missing after request");
    in_strobe_mode_a: assert property (
        chan_in_strobe |-> !xfer_mode_sel_a_n)
        else $error("input strobe in wrong mode");
    inc_no_input_a: assert property (inc_m |-> !chan_in_strobe)
        else $error("input strobe in increment mode");
    out_strobe_mode_a: assert property (
        $rose(chan_out_strobe) |-> !in_m)
        else $error("output strobe in input mode");
    inc_wrap_a: assert property (
        $rose(chan_out_strobe) && inc_m |->
        sum_wrap_pulse == (data_to_ctl == dch_pkg::DATA_ZERO))
        else $error("increment wrap pulse wrong");
    add_wrap_a: assert property (
        $rose(chan_out_strobe) && add_m |->
        sum_wrap_pulse == (data_to_ctl < data_to_cpu))
        else $error("add wrap pulse wrong");
    wrap_mode_only_a: assert property (
        sum_wrap_pulse |-> !xfer_mode_sel_b_n)
        else $error("wrap pulse in plain mode");
    wrap_one_cycle_a: assert property (
        sum_wrap_pulse |=> !sum_wrap_pulse)
        else $error("wrap pulse too long");
    add_in_first_a: assert property (
        $rose(chan_out_strobe) && add_m |-> $past(chan_in_strobe, 2))
        else $error("add output without input phase");
    strobe_len_a: assert property (
        $rose(chan_out_strobe) |=> ##[0:3] !chan_out_strobe)
        else $error("output strobe too long");
    mode_stable_a: assert property (
        chan_request && $past(chan_request) |->
        $stable({xfer_mode_sel_a_n, xfer_mode_sel_b_n}))
        else $error("mode lines moved in transfer");
    req_held_a: assert property (
        (chan_in_strobe || chan_out_strobe) |-> chan_request)
        else $error("request dropped during strobe");
    strobe_mode_a: assert property (
        (chan_in_strobe || chan_out_strobe) |->
        $stable({xfer_mode_sel_a_n, xfer_mode_sel_b_n}))
        else $error("mode lines moved during strobe");
    prio_chain_a: assert property (
        chan_prio_chain_out |-> chan_prio_chain_in)
        else $error("priority out without priority in");
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    localparam dch_pkg::xfer_mode_t m_out = dch_pkg::MODE_OUT;
    localparam dch_pkg::xfer_mode_t m_inc = dch_pkg::MODE_INC;
    localparam dch_pkg::xfer_mode_t m_in  = dch_pkg::MODE_IN;
    localparam dch_pkg::xfer_mode_t m_add = dch_pkg::MODE_ADD;
    logic                clk;
    logic                rst_n;
    logic                fast;
    logic                req;
    dch_pkg::xfer_mode_t req_mode;
    logic [7:0]          req_addr;
    logic [15:0]         req_data;
    logic                req_ready;
    logic [15:0]         rx_data;
    logic                rx_valid;
    logic                wrap_seen;
    logic                busy;
    int                  miscompares = 0;
    int                  checked = 0;
    dch_if bus_if();
    dch_cpu_end dch_cpu_end_inst (.clk(clk), .rst_n(rst_n),
        .fast_chassis(fast), .bus(bus_if), .busy(busy));
    dch_ctl_end dch_ctl_end_inst (.clk(clk), .rst_n(rst_n), .bus(bus_if),
        .req(req), .req_mode(req_mode), .req_addr(req_addr),
        .req_data(req_data), .req_ready(req_ready), .rx_data(rx_data),
        .rx_valid(rx_valid), .wrap_seen(wrap_seen));
    dch_properties dch_properties_inst (.clk(clk), .rst_n(rst_n),
        .data_to_ctl(bus_if.data_to_ctl), .data_to_cpu(bus_if.data_to_cpu),
        .chan_request(bus_if.chan_request), .chan_grant(bus_if.chan_grant),
        .xfer_mode_sel_a_n(bus_if.xfer_mode_sel_a_n),
        .xfer_mode_sel_b_n(bus_if.xfer_mode_sel_b_n),
        .chan_in_strobe(bus_if.chan_in_strobe),
        .chan_out_strobe(bus_if.chan_out_strobe),
        .sum_wrap_pulse(bus_if.sum_wrap_pulse),
        .chan_prio_chain_in(bus_if.chan_prio_chain_in),
        .chan_prio_chain_out(bus_if.chan_prio_chain_out));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic tally_and_finish();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic xfer(input dch_pkg::xfer_mode_t m, input logic [7:0] a,
        input logic [15:0] d, input logic [15:0] e, input logic w);
        int          i;
        int          len;
        int          exp_cyc;
        logic [15:0] got;
        logic        ws;
        got = 16'hxxxx;
        ws = 1'b0;
        len = fast ? dch_pkg::STROBE_FAST_CYC : dch_pkg::STROBE_STD_CYC;
        exp_cyc = (m == m_in) ? 2 + len :
                  (m == m_add) ? 3 + 2 * len : 3 + len;
        for (i = 0; i < 40 && req_ready !== 1'b1; i++) @(posedge clk) #1;
        if (i == 40) begin
            miscompares++;
            tally_and_finish();
        end
        req = 1'b1;
        req_mode = m;
        req_addr = a;
        req_data = d;
        @(posedge clk);
        #1;
        req = 1'b0;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            #1;
            if (rx_valid === 1'b1) got = rx_data;
            if (wrap_seen === 1'b1) ws = 1'b1;
            if (i > 2 && req_ready === 1'b1) break;
        end
        if (i == 40) begin
            miscompares++;
            tally_and_finish();
        end
        if (m != m_in) check(got, e);
        check({15'h0000, ws}, {15'h0000, w});
        check({15'h0000, bus_if.chan_prio_chain_out}, 16'h0001);
        check({15'h0000, busy}, 16'h0000);
        check(16'(i), 16'(exp_cyc));
    endtask
    initial begin
        rst_n = 1'b0;
        fast = 1'b1;
        req = 1'b0;
        req_mode = m_out;
        req_addr = 8'h00;
        req_data = 16'h0000;
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        for (int f = 1; f >= 0; f--) begin
            fast = f[0];
            xfer(m_in, 8'h05, 16'h1234, 16'h0000, 1'b0);
            xfer(m_out, 8'h05, 16'h0000, 16'h1234, 1'b0);
            xfer(m_in, 8'h06, 16'hffff, 16'h0000, 1'b0);
            xfer(m_inc, 8'h06, 16'h0000, 16'h0000, 1'b1);
            xfer(m_out, 8'h06, 16'h0000, 16'h0000, 1'b0);
            xfer(m_inc, 8'h06, 16'h0000, 16'h0001, 1'b0);
            xfer(m_add, 8'h06, 16'hfffe, 16'hffff, 1'b0);
            xfer(m_add, 8'h06, 16'h0002, 16'h0001, 1'b1);
            xfer(m_out, 8'h06, 16'h0000, 16'h0001, 1'b0);
        end
        tally_and_finish();
    end
endmodule
